// File: verilog/pcs_consts.svh
// Constants for the program counter and return stack unit.
// Assumes inclusion by bare name from package and modules.
// Function
// - 13-bit counter, low byte readable and writable
// - Upper bits seen only on pc, loaded via latch, vector or stack
// - Any reset clears upper counter bits
// - Low byte write copies latch bits 4:0
// - Call or jump: opcode 11 bits, latch 4:3
// - Eight by 13-bit stack, hidden pointer
// - Push on call or interrupt branch
// - Returns pop full 13-bit counter
// - Push and pop leave latch unchanged
// - Stack wraps, overwriting oldest entries in turn
// - No overflow or underflow indication at all
// - 8K word space in 2K pages
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_PC_W 13
`define PCS_LOW_W 8
`define PCS_UP_W 5
`define PCS_JMP_W 11
`define PCS_PAGE_W 2
`define PCS_STK_DEPTH 8
`define PCS_PTR_W 3
`define PCS_PC_RST 13'h0000
`define PCS_LATCH_RST 8'h00
`define PCS_PTR_RST 3'h0
`define PCS_PAGE_LSB 3
`endif

// File: verilog/pcs_pkg.sv
// Types shared by the program counter unit and its stack.
// Assumes the constants header is on the include path.
`include "pcs_consts.svh"
package pcs_pkg;
  typedef logic [`PCS_PC_W-1:0] pcs_addr_t;
  typedef logic [`PCS_PTR_W-1:0] pcs_ptr_t;
  // One-hot operation codes for the current instruction cycle
  typedef enum logic [5:0] {
    PCS_OP_NEXT = 6'h01,
    PCS_OP_WLOW = 6'h02,
    PCS_OP_JUMP = 6'h04,
    PCS_OP_CALL = 6'h08,
    PCS_OP_INTR = 6'h10,
    PCS_OP_RET  = 6'h20
  } pcs_op_t;
endpackage

// File: verilog/pcs_stack_if.sv
// Interface between the counter unit and its stack memory.
// Assumes both ends run on one clock.
`timescale 1ns/1ps
interface pcs_stack_if;
  logic wr_en;
  logic [2:0] wr_ptr;
  logic [12:0] wr_data;
  logic [2:0] rd_ptr;
  logic [12:0] rd_data;
  modport ctl (output wr_en, output wr_ptr, output wr_data,
    output rd_ptr, input rd_data);
  modport mem (input wr_en, input wr_ptr, input wr_data,
    input rd_ptr, output rd_data);
endinterface

// File: verilog/pcs_stack_mem.sv
// Eight-entry return address memory with registered read.
// Assumes the controller presents the read pointer one cycle early.
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_stack_mem (
  input wire logic clk,
  pcs_stack_if.mem sif
);
  import pcs_pkg::*;
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  typedef struct packed {
    logic [`PCS_STK_DEPTH-1:0][`PCS_PC_W-1:0] ent;
    logic [`PCS_PC_W-1:0] rd;
  } pcs_mem_st_t;
  pcs_mem_st_t st_r;
  pcs_mem_st_t st_nxt;
  // Write one entry, read the top entry; outside program and data space
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd = st_r.ent[sif.rd_ptr];
    if (sif.wr_en) begin
      st_nxt.ent[sif.wr_ptr] = sif.wr_data;
    end
  end
  // No reset on contents; stale entries pop silently
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end
  assign sif.rd_data = st_r.rd;
endmodule

// File: verilog/pcs_core.sv
// Program counter and return address stack of the core.
// Assumes decoder gives one operation per instruction cycle on clk.
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_core (
  input wire logic clk,
  input wire logic resetn,
  input wire pcs_pkg::pcs_op_t op,
  input wire logic [7:0] low_wr_data,
  input wire logic [10:0] jump_target,
  input wire logic [12:0] vector_addr,
  input wire logic latch_wr,
  input wire logic [7:0] latch_wr_data,
  output logic [12:0] pc,
  output logic [7:0] counter_low_byte_reg,
  output logic [7:0] high_address_holding_latch
);
  import pcs_pkg::*;
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pcs_addr_t pc;
    logic [7:0] latch;
    pcs_ptr_t ptr;
    logic pop_pend;
  } pcs_st_t;
  pcs_st_t st_r;
  pcs_st_t st_nxt;
  logic [`PCS_UP_W-1:0] up_bits;
  pcs_stack_if sif();
  pcs_stack_mem u_mem (
    .clk(clk),
    .sif(sif)
  );
  assign up_bits = st_r.latch[`PCS_UP_W-1:0];
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // The stack read is registered, so a return takes the popped value
  // one cycle later; the decoder idles that cycle (op NEXT ignored).
  always_comb begin
    st_nxt = st_r;
    st_nxt.pop_pend = 1'b0;
    sif.wr_en = 1'b0;
    sif.wr_data = st_r.pc + 13'h0001;
    sif.wr_ptr = st_r.ptr;
    sif.rd_ptr = st_r.ptr - 3'h1;
    if (latch_wr) begin
      st_nxt.latch = latch_wr_data;
    end
    if (st_r.pop_pend) begin
      st_nxt.pc = sif.rd_data;
    end else begin
      case (op)
        PCS_OP_NEXT: begin
          st_nxt.pc = st_r.pc + 13'h0001;
        end
        PCS_OP_WLOW: begin
          st_nxt.pc = {up_bits, low_wr_data};
        end
        PCS_OP_JUMP: begin
          st_nxt.pc = {st_r.latch[4:`PCS_PAGE_LSB], jump_target};
        end
        PCS_OP_CALL: begin
          sif.wr_en = 1'b1;
          st_nxt.ptr = st_r.ptr + 3'h1;
          st_nxt.pc = {st_r.latch[4:`PCS_PAGE_LSB], jump_target};
        end
        PCS_OP_INTR: begin
          sif.wr_en = 1'b1;
          sif.wr_data = st_r.pc;
          st_nxt.ptr = st_r.ptr + 3'h1;
          st_nxt.pc = vector_addr;
        end
        PCS_OP_RET: begin
          // Underflow wraps with no flag; latch untouched
          st_nxt.ptr = st_r.ptr - 3'h1;
          st_nxt.pop_pend = 1'b1;
        end
        default: begin
          st_nxt.pc = st_r.pc;
        end
      endcase
    end
  end
  // Any reset clears the whole counter, upper bits included
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r.pc <= `PCS_PC_RST;
      st_r.latch <= `PCS_LATCH_RST;
      st_r.ptr <= `PCS_PTR_RST;
      st_r.pop_pend <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // The low byte is exported as the readable register; pc also exports all 13 counter bits
  assign pc = st_r.pc;
  assign counter_low_byte_reg = st_r.pc[`PCS_LOW_W-1:0];
  assign high_address_holding_latch = st_r.latch;
endmodule

// File: tb/pcs_checker.sv
// Port checker for the counter unit.
// Assumes one clock and an active low reset.
`timescale 1ns/1ps
module pcs_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire pcs_pkg::pcs_op_t op,
  input wire logic [7:0] low_wr_data,
  input wire logic [10:0] jump_target,
  input wire logic [12:0] vector_addr,
  input wire logic latch_wr,
  input wire logic [7:0] latch_wr_data,
  input wire logic [12:0] pc,
  input wire logic [7:0] counter_low_byte_reg,
  input wire logic [7:0] high_address_holding_latch
);
  import pcs_pkg::*;
  logic rr;
  wire br = op == PCS_OP_JUMP || op == PCS_OP_CALL;
  wire [7:0] hl = high_address_holding_latch;
  // A return hides the next operation
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) rr <= 1'b0;
    else rr <= op == PCS_OP_RET && !rr;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_cr;
    op == PCS_OP_CALL && !rr ##1 op == PCS_OP_RET;
  endsequence
  a_low_mirror: assert property (counter_low_byte_reg == pc[7:0])
    else $error("low byte");
  a_step_one: assert property (op == PCS_OP_NEXT && !rr |=>
    pc == $past(pc) + 13'h1) else $error("step");
  a_low_load: assert property (op == PCS_OP_WLOW && !rr |=>
    pc == {$past(hl[4:0]), $past(low_wr_data)}) else $error("low");
  a_page_jump: assert property (br && !rr |=>
    pc == {$past(hl[4:3]), $past(jump_target)}) else $error("jump");
  a_vector_take: assert property (op == PCS_OP_INTR && !rr |=>
    pc == $past(vector_addr)) else $error("vector");
  a_latch_hold: assert property (!latch_wr |=> $stable(hl))
    else $error("latch");
  a_call_ret: assert property (s_cr |-> ##2 pc == $past(pc, 3) + 13'h1)
    else $error("return");
  a_reset_zero: assert property (disable iff (1'b0)
    !resetn |-> pc == 13'h0000) else $error("reset");
endmodule
bind pcs_core pcs_checker u_chk (.clk, .resetn, .op, .low_wr_data,
  .jump_target, .vector_addr, .latch_wr, .latch_wr_data, .pc,
  .counter_low_byte_reg, .high_address_holding_latch);

// File: tb/pcs_decoder_model.sv
// Decoder stand-in, one operation per cycle.
// Assumes put is called at a rising edge.
`timescale 1ns/1ps
module pcs_decoder_model (
  output pcs_pkg::pcs_op_t op,
  output logic [7:0] low_wr_data,
  output logic [10:0] jump_target,
  output logic [12:0] vector_addr,
  output logic latch_wr,
  output logic [7:0] latch_wr_data
);
  import pcs_pkg::*;
  // Page bits are set before branches, tables stay in one byte
  task put(input pcs_op_t o, input logic [12:0] d, input logic l,
    input logic [7:0] ld);
    op <= o;
    low_wr_data <= d[7:0];
    jump_target <= d[10:0];
    vector_addr <= d;
    latch_wr <= l;
    latch_wr_data <= ld;
  endtask
  initial put(PCS_OP_NEXT, 13'h0000, 1'b0, 8'h00);
endmodule

// File: tb/tb.sv
// Bench: counter unit against an integer model.
// Assumes checker and decoder model compiled first.
`timescale 1ns/1ps
module tb;
  import pcs_pkg::*;
  logic clk, resetn, latch_wr;
  pcs_op_t op;
  logic [7:0] low_wr_data, latch_wr_data, lo, hl;
  logic [10:0] jump_target;
  logic [12:0] vector_addr, pc;
  int m, lt, sp, skip, ign, i, miscompares, check_count;
  int st[8];
  pcs_core dut (.clk, .resetn, .op, .low_wr_data, .jump_target,
    .vector_addr, .latch_wr, .latch_wr_data, .pc,
    .counter_low_byte_reg(lo), .high_address_holding_latch(hl));
  pcs_decoder_model u_dec (.op, .low_wr_data, .jump_target,
    .vector_addr, .latch_wr, .latch_wr_data);
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [12:0] g, input logic [12:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task test_done;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Drive one op, check the last result, advance the model
  task step(input pcs_op_t o, input int d, input logic l, input int ld);
    u_dec.put(o, d[12:0], l, ld[7:0]);
    #1;
    if (skip) skip = 0;
    else begin
      chk(pc, m[12:0]);
      chk({5'h00, hl}, lt[12:0]);
      chk({5'h00, lo}, m[12:0] & 13'h00FF);
    end
    if (ign) ign = 0;
    else case (o)
      PCS_OP_NEXT: m = (m + 1) & 8191;
      PCS_OP_WLOW: m = (lt & 31) * 256 + (d & 255);
      PCS_OP_JUMP: m = (lt & 24) * 256 + (d & 2047);
      PCS_OP_CALL, PCS_OP_INTR: begin
        st[sp] = o == PCS_OP_CALL ? (m + 1) & 8191 : m;
        sp = (sp + 1) % 8;
        if (o == PCS_OP_CALL) m = (lt & 24) * 256 + (d & 2047);
        else m = d & 8191;
      end
      default: begin
        sp = (sp + 7) % 8;
        m = st[sp];
        skip = 1;
        ign = 1;
      end
    endcase
    if (l) lt = ld & 255;
    @(posedge clk);
  endtask
  initial begin
    #(3000 * 50);
    miscompares++;
    test_done;
  end
  initial begin
    i = $urandom(32'hAB298751);
    resetn = 0;
    repeat (10) @(posedge clk);
    resetn <= 1;
    // Every page: latch load, low write, jump
    for (i = 0; i < 8; i++) begin
      step(PCS_OP_NEXT, 0, 1, $urandom & 231 | i % 4 * 8);
      step(PCS_OP_WLOW, $urandom, 0, 0);
      step(PCS_OP_JUMP, $urandom, 0, 0);
    end
    $display("paging test done");
    // Ten pushes wrap, ten pops unwind silently
    for (i = 0; i < 10; i++)
      step(i == 4 ? PCS_OP_INTR : PCS_OP_CALL, $urandom, 0, 0);
    for (i = 0; i < 20; i++)
      step(i % 2 ? PCS_OP_NEXT : PCS_OP_RET, 0, 0, 0);
    step(PCS_OP_CALL, $urandom, 0, 0);
    step(PCS_OP_RET, 0, 0, 0);
    step(PCS_OP_NEXT, 0, 0, 0);
    step(PCS_OP_NEXT, 0, 0, 0);
    $display("stack test done");
    // Reset in mid-run clears the counter
    resetn <= 0;
    #1 chk(pc, 0);
    m = 0;
    lt = 0;
    sp = 0;
    @(posedge clk);
    resetn <= 1;
    repeat (3) step(PCS_OP_NEXT, 0, 0, 0);
    $display("reset test done");
    test_done;
  end
endmodule
